// *** rtl/fec_top.sv ***
// Filter configuration and coefficient registers behind an APB slave
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "fec_cfg.svh"
module fec_top (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`FEC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_link_enable,
    output logic filter_enable,
    output logic filter_bypass,
    output logic filter_merge,
    output logic coefficient_share,
    output logic [2:0] side_coefficient_weight,
    output logic [`FEC_SIDE_W-1:0] tap0_coefficient,
    output logic [`FEC_SIDE_W-1:0] tap1_coefficient,
    output logic [`FEC_SIDE_W-1:0] tap2_coefficient,
    output logic [`FEC_SIDE_W-1:0] tap3_coefficient,
    output logic [`FEC_CTR_W-1:0] center_tap_coefficient
);
    import fec_pkg::*;

    // ======================================================================
    // Declarations
    fec_state_t s_r;
    fec_state_t s_nxt;

    logic [`FEC_IDX_W-1:0] idx;
    logic aligned;
    logic hit_cfg;
    logic hit_ctr;
    logic hit_stat;
    logic [`FEC_NUM_SIDE-1:0] hit_tap;
    logic setup;
    logic access;
    logic wr;
    logic filt_wr;
    logic [`FEC_NUM_SIDE-1:0] tap_we;
    logic ctr_we;
    logic [`FEC_SIDE_W-1:0] tap_coef [`FEC_NUM_SIDE];
    logic [`FEC_SIDE_W-1:0] tap_rd [`FEC_NUM_SIDE];
    logic [`FEC_SIDE_W-1:0] tap_wd [`FEC_NUM_SIDE];
    logic [`FEC_CTR_W-1:0] ctr_coef;
    logic [`FEC_CTR_W-1:0] ctr_rd;
    logic [`FEC_CTR_W-1:0] ctr_wd;

    // ======================================================================
    // Address decode
    assign idx = paddr[`FEC_ADDR_W-1:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign hit_cfg = aligned && (idx == `FEC_IDX_CFG);
    assign hit_ctr = aligned && (idx == `FEC_IDX_CTR);
    assign hit_stat = aligned && (idx == `FEC_IDX_STAT);
    assign setup = psel && !penable;
    assign access = psel && penable && s_r.pready;
    assign wr = access && pwrite && !s_r.pslverr;
    // Only the filter's own registers are frozen while the link runs
    assign filt_wr = wr && (hit_cfg || hit_ctr || (|hit_tap));

    // ======================================================================
    // Side coefficient registers, spaced two indices apart
    genvar gi;
    generate
        for (gi = 0; gi < `FEC_NUM_SIDE; gi++) begin : g_tap
            assign hit_tap[gi] = aligned &&
                (idx == `FEC_IDX_TAP0 + `FEC_IDX_W'(gi) * `FEC_TAP_STEP);
            // Writes are ignored while the link is enabled
            assign tap_we[gi] = filt_wr && !serial_link_enable && hit_tap[gi];
            assign tap_wd[gi] = {pstrb[1] ? pwdata[11:8] : tap_coef[gi][11:8],
                                 pstrb[0] ? pwdata[7:0] : tap_coef[gi][7:0]};
            fec_coef_reg #(
                .W(`FEC_SIDE_W),
                .RST(`FEC_SIDE_RST)
            ) u_tap (
                .clk(clk),
                .rstn(rstn),
                .wr_en(tap_we[gi]),
                .wr_data(tap_wd[gi]),
                .coef(tap_coef[gi]),
                .rd_data(tap_rd[gi])
            );
        end
    endgenerate

    // ======================================================================
    // Center coefficient register
    assign ctr_we = filt_wr && !serial_link_enable && hit_ctr;
    assign ctr_wd = {pstrb[2] ? pwdata[17:16] : ctr_coef[17:16],
                     pstrb[1] ? pwdata[15:8] : ctr_coef[15:8],
                     pstrb[0] ? pwdata[7:0] : ctr_coef[7:0]};

    fec_coef_reg #(
        .W(`FEC_CTR_W),
        .RST(`FEC_CTR_RST)
    ) u_center (
        .clk(clk),
        .rstn(rstn),
        .wr_en(ctr_we),
        .wr_data(ctr_wd),
        .coef(ctr_coef),
        .rd_data(ctr_rd)
    );

    // ======================================================================
    // Next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.pready = 1'b0;
        s_nxt.pslverr = 1'b0;
        // One wait-free access phase: answer prepared in the setup cycle
        if (setup) begin
            s_nxt.pready = 1'b1;
            s_nxt.pslverr = !(hit_cfg || hit_ctr || hit_stat || (|hit_tap));
            s_nxt.prdata = 32'h0000_0000;
            if (hit_cfg) begin
                s_nxt.prdata[7:0] = s_r.cfg;
            end else if (hit_stat) begin
                s_nxt.prdata[`FEC_STAT_REFUSED_BIT] = s_r.refused;
                s_nxt.prdata[`FEC_STAT_LINK_BIT] = serial_link_enable;
            end else if (hit_ctr) begin
                s_nxt.prdata[`FEC_CTR_W-1:0] = ctr_rd;
            end else begin
                for (int i = 0; i < `FEC_NUM_SIDE; i++) begin
                    if (hit_tap[i]) begin
                        s_nxt.prdata[`FEC_SIDE_W-1:0] = tap_rd[i];
                    end
                end
            end
        end
        // Configuration byte, reserved mode codes are stored as written
        if (filt_wr && !serial_link_enable && hit_cfg && pstrb[0]) begin
            s_nxt.cfg = fec_cfg_t'(pwdata[7:0]);
        end
        // Refused-write flag: clear first so a same-cycle refusal wins
        if (wr && hit_stat && pstrb[0] && pwdata[`FEC_STAT_REFUSED_BIT]) begin
            s_nxt.refused = 1'b0;
        end
        if (filt_wr && serial_link_enable) begin
            s_nxt.refused = 1'b1;
        end
        // Only code 2 turns the filter on; 1 and 3 act as off
        s_nxt.enable = (s_nxt.cfg.mode == `FEC_MODE_ON);
        s_nxt.bypass = !s_nxt.enable;
        // Weights above 6 are outside the range, held at 6
        s_nxt.weight = (s_nxt.cfg.scw > `FEC_SCW_MAX) ? `FEC_SCW_MAX : s_nxt.cfg.scw;
    end

    // ======================================================================
    // State register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '{cfg: fec_cfg_t'(`FEC_CFG_RST), enable: 1'b0, bypass: 1'b1, weight: 3'h0,
                     refused: 1'b0, pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ======================================================================
    // Outputs
    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign filter_enable = s_r.enable;
    assign filter_bypass = s_r.bypass;
    assign filter_merge = s_r.cfg.merge;
    assign coefficient_share = s_r.cfg.share;
    assign side_coefficient_weight = s_r.weight;
    assign tap0_coefficient = tap_coef[0];
    assign tap1_coefficient = tap_coef[1];
    assign tap2_coefficient = tap_coef[2];
    assign tap3_coefficient = tap_coef[3];
    assign center_tap_coefficient = ctr_coef;

    // ======================================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_write(logic hit);
        psel && penable && pready && pwrite && !pslverr && hit && pstrb[0] && pstrb[1];
    endsequence

    a_setup_answer: assert property (s_setup |=> pready && !$past(pready))
        else $error("setup cycle not answered in one cycle");

    a_mode_enable: assert property (
        s_write(hit_cfg) and (!serial_link_enable) |=>
        filter_enable == ($past(pwdata[1:0]) == 2'h2) && filter_bypass == !filter_enable)
        else $error("filter enable does not follow mode code");

    a_write_locked: assert property (
        s_write(hit_tap[0]) and serial_link_enable |=> $stable(tap0_coefficient) && s_r.refused)
        else $error("coefficient changed while link enabled");

    a_tap0_load: assert property (
        s_write(hit_tap[0]) and (!serial_link_enable) |=> tap0_coefficient == $past(pwdata[11:0]))
        else $error("first tap not loaded from its register");

    a_tap3_load: assert property (
        s_write(hit_tap[3]) and (!serial_link_enable) |=> tap3_coefficient == $past(pwdata[11:0]))
        else $error("fourth tap not loaded from its register");

    a_tap_read_mask: assert property (
        s_setup and hit_tap[1] |=> prdata[31:11] == 21'h0 && prdata[10:0] == tap1_coefficient[10:0])
        else $error("side tap readback wrong");

    a_weight_range: assert property (
        side_coefficient_weight <= 3'h6 && (filter_bypass != filter_enable))
        else $error("side weight outside range or bypass inconsistent");

    a_share_merge: assert property (
        s_write(hit_cfg) and (!serial_link_enable) |=>
        coefficient_share == $past(pwdata[6]) && filter_merge == $past(pwdata[5]))
        else $error("share or merge not taken from configuration");

    a_center_read: assert property (
        s_setup and hit_ctr |=> prdata[31:17] == 15'h0 && prdata[16:0] == center_tap_coefficient[16:0])
        else $error("center tap readback wrong");

    a_refused_sticky: assert property (
        s_r.refused && !(psel && penable && pwrite && hit_stat) |=> s_r.refused)
        else $error("refused flag lost without a clear");

    sequence s_low_lane_write(logic hit);
        psel && penable && pready && pwrite && !pslverr && hit && pstrb[0] && !pstrb[1];
    endsequence

    a_tap1_load: assert property (
        s_write(hit_tap[1]) and (!serial_link_enable) |=> tap1_coefficient == $past(pwdata[11:0]))
        else $error("second tap not loaded from its register");

    a_tap2_load: assert property (
        s_write(hit_tap[2]) and (!serial_link_enable) |=> tap2_coefficient == $past(pwdata[11:0]))
        else $error("third tap not loaded from its register");

    a_center_load: assert property (
        s_write(hit_ctr) and (!serial_link_enable && pstrb[2]) |=> center_tap_coefficient == $past(pwdata[17:0]))
        else $error("center tap not loaded from its register");

    a_lane_keep: assert property (
        s_low_lane_write(hit_tap[1]) and (!serial_link_enable) |=>
        tap1_coefficient[7:0] == $past(pwdata[7:0]) && $stable(tap1_coefficient[11:8]))
        else $error("unstrobed byte lane of a side tap changed");

    a_reserved_off: assert property (
        s_write(hit_cfg) and (!serial_link_enable && pwdata[0]) |=> !filter_enable && filter_bypass)
        else $error("reserved mode code turned the filter on");

    a_weight_clamp: assert property (
        s_write(hit_cfg) and (!serial_link_enable) |=>
        side_coefficient_weight == (($past(pwdata[4:2]) > `FEC_SCW_MAX) ? `FEC_SCW_MAX : $past(pwdata[4:2])))
        else $error("side weight not taken from configuration");

    a_cfg_locked: assert property (
        s_write(hit_cfg) and serial_link_enable |=> $stable(s_r.cfg) && s_r.refused)
        else $error("configuration changed while link enabled");

    a_ctr_locked: assert property (
        s_write(hit_ctr) and serial_link_enable |=> $stable(center_tap_coefficient) && s_r.refused)
        else $error("center tap changed while link enabled");

    a_tap3_locked: assert property (
        s_write(hit_tap[3]) and serial_link_enable |=> $stable(tap3_coefficient) && s_r.refused)
        else $error("fourth tap changed while link enabled");

    a_status_read: assert property (
        s_setup and hit_stat |=>
        prdata[31:2] == 30'h0 && prdata[1] == $past(serial_link_enable) && prdata[0] == $past(s_r.refused))
        else $error("status readback wrong");

    a_cfg_read: assert property (
        s_setup and hit_cfg |=> prdata[31:8] == 24'h00_0000 && prdata[1:0] == $past(s_r.cfg.mode))
        else $error("configuration readback wrong");

    a_tap0_read: assert property (
        s_setup and hit_tap[0] |=> prdata[31:11] == 21'h0 && prdata[10:0] == tap0_coefficient[10:0])
        else $error("first tap readback wrong");

    a_tap3_read: assert property (
        s_setup and hit_tap[3] |=> prdata[31:11] == 21'h0 && prdata[10:0] == tap3_coefficient[10:0])
        else $error("fourth tap readback wrong");

endmodule : fec_top

// *** rtl/fec_cfg.svh ***
// Offsets, field positions, reset values and fixed figures of the filter configuration block
`ifndef FEC_CFG_SVH
`define FEC_CFG_SVH

// ==========================================================================
// Bus geometry
`define FEC_ADDR_W 16
`define FEC_IDX_W 14

// ==========================================================================
// Register indices, byte address is four times the index
`define FEC_IDX_CFG 14'h0400
`define FEC_IDX_TAP0 14'h0418
`define FEC_IDX_TAP1 14'h041A
`define FEC_IDX_TAP2 14'h041C
`define FEC_IDX_TAP3 14'h041E
`define FEC_IDX_CTR 14'h0420
`define FEC_IDX_STAT 14'h0401
`define FEC_TAP_STEP 14'h0002

// ==========================================================================
// Configuration fields
`define FEC_CFG_MODE_LSB 0
`define FEC_CFG_SCW_LSB 2
`define FEC_CFG_MERGE_BIT 5
`define FEC_CFG_SHARE_BIT 6
`define FEC_MODE_OFF 2'h0
`define FEC_MODE_ON 2'h2
`define FEC_SCW_MAX 3'h6

// ==========================================================================
// Status fields
`define FEC_STAT_REFUSED_BIT 0
`define FEC_STAT_LINK_BIT 1

// ==========================================================================
// Widths and reset values
`define FEC_SIDE_W 12
`define FEC_CTR_W 18
`define FEC_NUM_SIDE 4
`define FEC_CFG_RST 8'h00
`define FEC_SIDE_RST 12'h000
`define FEC_CTR_RST 18'h00000

`endif

// *** rtl/fec_pkg.sv ***
// Types shared by the filter configuration block
package fec_pkg;

    // ======================================================================
    // Configuration byte layout
    typedef struct packed {
        logic       spare;
        logic       share;
        logic       merge;
        logic [2:0] scw;
        logic [1:0] mode;
    } fec_cfg_t;

    // ======================================================================
    // State of the top level apart from the coefficient registers
    typedef struct packed {
        fec_cfg_t    cfg;
        logic        enable;
        logic        bypass;
        logic [2:0]  weight;
        logic        refused;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } fec_state_t;

endpackage : fec_pkg

// *** rtl/fec_coef_reg.sv ***
// One signed coefficient register with its masked readback
`timescale 1ns/1ps
module fec_coef_reg #(
    parameter int W = 12,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wr_en,
    input wire logic [W-1:0] wr_data,
    output logic [W-1:0] coef,
    output logic [W-1:0] rd_data
);
    typedef struct packed {
        logic [W-1:0] value;
    } fec_coef_state_t;

    fec_coef_state_t s_r;
    fec_coef_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (wr_en) begin
            s_nxt.value = wr_data;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '{value: RST};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign coef = s_r.value;
    // Stored sign bit is never returned on a read
    assign rd_data = {1'b0, s_r.value[W-2:0]};

    a_msb_hidden: assert property (@(posedge clk) disable iff (!rstn)
        rd_data[W-1] == 1'b0 && rd_data[W-2:0] == coef[W-2:0])
        else $error("coefficient readback shows its sign bit");

endmodule : fec_coef_reg

// *** dv/fec_top_test.sv ***
// Self-checking bench for the filter configuration block
`timescale 1ns/1ps
`include "fec_cfg.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
    $display("[ERR] %0t got %h expected %h", $time, (a), (b)); end end
module fec_top_test;
    // ======================================================================
    // Stimulus and observed signals
    typedef struct packed {
        logic [15:0] a;
        logic [31:0] d;
        logic [31:0] q;
        logic e;
    } fec_row_t;
    localparam logic [15:0] A_CFG = {`FEC_IDX_CFG, 2'b00};
    localparam logic [15:0] A_STAT = {`FEC_IDX_STAT, 2'b00};
    localparam logic [15:0] A_TAP0 = {`FEC_IDX_TAP0, 2'b00};
    localparam fec_row_t ROWS [7] = '{
        '{A_CFG, 32'h0000_0002, 32'h0000_0002, 1'b0},
        '{A_TAP0, 32'h0000_FFFF, 32'h0000_07FF, 1'b0},
        '{{`FEC_IDX_TAP1, 2'b00}, 32'h0000_0123, 32'h0000_0123, 1'b0},
        '{{`FEC_IDX_TAP2, 2'b00}, 32'h0000_0ABC, 32'h0000_02BC, 1'b0},
        '{{`FEC_IDX_TAP3, 2'b00}, 32'h0000_0800, 32'h0000_0000, 1'b0},
        '{{`FEC_IDX_CTR, 2'b00}, 32'h0003_FFFF, 32'h0001_FFFF, 1'b0},
        '{16'h1062, 32'h0000_0001, 32'h0000_0000, 1'b1}};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hF;
    logic serial_link_enable = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, filter_enable, filter_bypass, filter_merge, coefficient_share;
    logic [2:0] side_coefficient_weight;
    logic [11:0] tap0_coefficient, tap1_coefficient, tap2_coefficient, tap3_coefficient;
    logic [17:0] center_tap_coefficient;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;

    always #2 clk = ~clk;

    fec_top dut_u (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_link_enable(serial_link_enable), .filter_enable(filter_enable),
        .filter_bypass(filter_bypass), .filter_merge(filter_merge), .coefficient_share(coefficient_share),
        .side_coefficient_weight(side_coefficient_weight), .tap0_coefficient(tap0_coefficient),
        .tap1_coefficient(tap1_coefficient), .tap2_coefficient(tap2_coefficient),
        .tap3_coefficient(tap3_coefficient), .center_tap_coefficient(center_tap_coefficient));

    // ======================================================================
    // Bus tasks and closing
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] q, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        // Master waits on pready, never on a fixed count
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, s, q, e);
        // Outputs settle one edge after the access
        @(negedge clk);
    endtask : wr

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            close_out();
        end
    end

    // ======================================================================
    // Main sequence
    initial begin
        logic [31:0] q;
        logic e;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        `CHK({filter_enable, filter_bypass}, 2'b01)
        apb(1'b0, A_CFG, 32'h0, 4'hF, q, e);
        `CHK(q, 32'h0000_0000)
        for (int i = 0; i < 7; i++) begin
            wr(ROWS[i].a, ROWS[i].d, 4'hF);
            apb(1'b0, ROWS[i].a, 32'h0, 4'hF, q, e);
            `CHK({e, q}, {ROWS[i].e, ROWS[i].q})
        end
        `CHK(tap0_coefficient, 12'hFFF)
        `CHK(tap1_coefficient, 12'h123)
        `CHK(tap2_coefficient, 12'hABC)
        `CHK(tap3_coefficient, 12'h800)
        `CHK(center_tap_coefficient, 18'h3FFFF)
        wr({`FEC_IDX_TAP1, 2'b00}, 32'h0000_F0FF, 4'h1);
        `CHK(tap1_coefficient, 12'h1FF)
        for (int i = 0; i < 4; i++) begin
            wr(A_CFG, 32'(i), 4'hF);
            `CHK(filter_enable, 1'(i == 2))
            `CHK(filter_bypass, 1'(i != 2))
        end
        for (int i = 0; i < 8; i++) begin
            wr(A_CFG, 32'(i << 2), 4'hF);
            `CHK(side_coefficient_weight, (i > 6) ? 3'h6 : 3'(i))
        end
        wr(A_CFG, 32'h0000_0040, 4'hF);
        `CHK({coefficient_share, filter_merge}, 2'b10)
        wr(A_CFG, 32'h0000_0020, 4'hF);
        `CHK({coefficient_share, filter_merge}, 2'b01)
        // Writes while the link runs must leave the taps alone
        @(posedge clk);
        serial_link_enable <= 1'b1;
        wr(A_TAP0, 32'h0000_0555, 4'hF);
        `CHK(tap0_coefficient, 12'hFFF)
        wr({`FEC_IDX_TAP3, 2'b00}, 32'h0000_0111, 4'hF);
        `CHK(tap3_coefficient, 12'h800)
        wr({`FEC_IDX_CTR, 2'b00}, 32'h0000_0000, 4'hF);
        `CHK(center_tap_coefficient, 18'h3FFFF)
        wr(A_CFG, 32'h0000_0042, 4'hF);
        `CHK({filter_enable, coefficient_share, filter_merge}, 3'b001)
        apb(1'b0, A_STAT, 32'h0, 4'hF, q, e);
        `CHK(q[1:0], 2'b11)
        @(posedge clk);
        serial_link_enable <= 1'b0;
        wr(A_STAT, 32'h0000_0001, 4'hF);
        apb(1'b0, A_STAT, 32'h0, 4'hF, q, e);
        `CHK(q[1:0], 2'b00)
        wr(A_TAP0, 32'h0000_0555, 4'hF);
        `CHK(tap0_coefficient, 12'h555)
        // Reset in mid-run restores every default
        @(posedge clk);
        rstn <= 1'b0;
        @(negedge clk);
        `CHK({filter_enable, filter_bypass, filter_merge, coefficient_share}, 4'b0100)
        `CHK({tap0_coefficient, tap3_coefficient, center_tap_coefficient}, 42'h0)
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        apb(1'b0, {`FEC_IDX_TAP2, 2'b00}, 32'h0, 4'hF, q, e);
        `CHK(q, 32'h0000_0000)
        close_out();
    end
endmodule : fec_top_test
